// ---- bench/dcf_link_partner.sv ----
// Write-side and read-side controlling logic facing the FIFO core.
// Assumes the bench calls its tasks; each link clock pulse is one frame.
`timescale 1ns/1ps
module dcf_link_partner #(
    parameter int DW = 18
) (
    input wire logic clock,
    output logic wclk,
    output logic wen_n,
    output logic [DW-1:0] wdata,
    output logic rclk,
    output logic ren_n,
    output logic got
);

    initial begin
        wclk = 1'b0;
        wen_n = 1'b1;
        wdata = '0;
        rclk = 1'b0;
        ren_n = 1'b1;
        got = 1'b0;
    end

    task automatic edges(input int n);
        repeat (n) @(posedge clock);
    endtask : edges

    ////////////////////////////////////////////////////////////////////
    // One write clock period of 800 ns; clock idles low between frames
    // write enable low writes
    task automatic wcyc(input logic we, input logic [DW-1:0] d);
        @(posedge clock);
        wen_n <= ~we;
        wdata <= d;
        edges(1);
        wclk <= 1'b1;
        edges(4);
        wclk <= 1'b0;
        wen_n <= 1'b1;
        // Released data shows the inverse, never a stale copy
        wdata <= ~d;
        edges(2);
    endtask : wcyc

    ////////////////////////////////////////////////////////////////////
    // read enable low requests a word; got strobes only a requested word
    task automatic rcyc(input logic rd);
        @(posedge clock);
        ren_n <= ~rd;
        edges(1);
        rclk <= 1'b1;
        edges(4);
        rclk <= 1'b0;
        // Output word settled an edge before this strobe
        got <= rd;
        edges(1);
        got <= 1'b0;
        ren_n <= 1'b1;
        edges(1);
    endtask : rcyc

endmodule : dcf_link_partner

// ---- bench/tb.sv ----
// Self-checking bench of the dual-clock FIFO core, both timing modes.
// Assumes the real small depth; counts stay far below it.
`timescale 1ns/1ps
`include "dcf_cfg.svh"
module tb;

    logic clock = 1'b0;
    logic rstn;
    logic mode_select_serial_in;
    logic offset_load_n;
    logic serial_en_n;
    logic [7:0] reg_addr;
    logic [31:0] reg_wdata;
    logic reg_wr;
    logic reg_rd;
    logic [31:0] reg_rdata;
    logic [`DCF_WIDTH-1:0] read_data_out;
    logic [`DCF_WIDTH-1:0] wdata;
    logic wclk, wen_n, rclk, ren_n, got;
    logic empty_indicator_n, output_ready_n, full_indicator_n;
    logic input_room_n, almost_empty_n, almost_full_n, half_full_n;
    int failures = 0;
    int comparisons = 0;
    int cycles = 0;
    int seed = 32'h62e1;
    logic [`DCF_WIDTH-1:0] exp_q[$];
    logic [`DCF_WIDTH-1:0] d[4];
    logic [31:0] v;
    logic [33:0] sbits;

    always #50 clock = ~clock;

    dcf_link_partner #(.DW(`DCF_WIDTH)) p (.clock(clock), .wclk(wclk),
        .wen_n(wen_n), .wdata(wdata), .rclk(rclk), .ren_n(ren_n),
        .got(got));

    dcf_fifo_core #(.DW(`DCF_WIDTH), .DEPTH(`DCF_DEPTH_SMALL)) DUT (
        .clock(clock), .rstn(rstn), .wclk(wclk), .wen_n(wen_n),
        .wdata(wdata), .rclk(rclk), .ren_n(ren_n),
        .mode_select_serial_in(mode_select_serial_in),
        .offset_load_n(offset_load_n), .serial_en_n(serial_en_n),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .read_data_out(read_data_out),
        .empty_indicator_n(empty_indicator_n),
        .output_ready_n(output_ready_n),
        .full_indicator_n(full_indicator_n), .input_room_n(input_room_n),
        .almost_empty_n(almost_empty_n), .almost_full_n(almost_full_n),
        .half_full_n(half_full_n));

    ////////////////////////////////////////////////////////////////////
    task automatic chk(input string name, input logic [31:0] seen,
                       input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            failures++;
            $display("mismatch %s expected %h seen %h", name, exp, seen);
        end
    endtask : chk

    task automatic finish_test();
        $display("failures %0d comparisons %0d", failures, comparisons);
        if (failures == 0 && comparisons > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : finish_test

    task automatic reg_write(input logic [7:0] a, input logic [31:0] dv);
        @(posedge clock);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= dv;
        @(posedge clock);
        reg_wr <= 1'b0;
    endtask : reg_write

    task automatic reg_read(input logic [7:0] a, output logic [31:0] rv);
        @(posedge clock);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clock);
        reg_rd <= 1'b0;
        #1 rv = reg_rdata;
    endtask : reg_read

    // Straps held through reset and the strap phase after it
    task automatic do_reset(input logic mode, input logic ld);
        @(posedge clock);
        rstn <= 1'b0;
        mode_select_serial_in <= mode;
        offset_load_n <= ld;
        repeat (12) @(posedge clock);
        rstn <= 1'b1;
        repeat (10) @(posedge clock);
        // Low load pin would block memory writes
        offset_load_n <= 1'b1;
    endtask : do_reset

    task automatic rticks(input int n);
        repeat (n) p.rcyc(1'b0);
    endtask : rticks

    ////////////////////////////////////////////////////////////////////
    // Watcher: each read strobe consumes the oldest expected word
    always @(posedge clock) begin
        cycles++;
        if (got === 1'b1 && exp_q.size() > 0) begin
            chk("read_data_out", 32'(read_data_out), 32'(exp_q.pop_front()));
        end else if (got === 1'b1) begin
            chk("read_strobe", 32'h1, 32'h0);
        end
        if (cycles >= 20000) begin
            failures++;
            finish_test();
        end
    end

    ////////////////////////////////////////////////////////////////////
    initial begin
        rstn <= 1'b0;
        mode_select_serial_in <= 1'b0;
        offset_load_n <= 1'b0;
        serial_en_n <= 1'b1;
        reg_addr <= 8'h00;
        reg_wdata <= 32'h0;
        reg_wr <= 1'b0;
        reg_rd <= 1'b0;
        do_reset(1'b0, 1'b0);
        reg_read(`DCF_ADDR_EMPTY_OFS, v);
        chk("empty_ofs", v, `DCF_OFS_PARALLEL);
        reg_read(`DCF_ADDR_FULL_OFS, v);
        chk("full_ofs", v, `DCF_OFS_PARALLEL);
        reg_read(`DCF_ADDR_STATUS, v);
        chk("mode_bits", v & 32'h3, 32'h0);
        reg_read(8'h10, v);
        chk("unmapped", v, 32'h0);
        // Offsets chosen so both partial flags move within four words
        reg_write(`DCF_ADDR_EMPTY_OFS, 32'h2);
        reg_write(`DCF_ADDR_FULL_OFS, 32'(`DCF_DEPTH_SMALL - 4));
        reg_read(`DCF_ADDR_FULL_OFS, v);
        chk("full_ofs", v, 32'(`DCF_DEPTH_SMALL - 4));
        chk("empty_n", 32'(empty_indicator_n), 32'h0);
        exp_q.push_back('0);
        p.rcyc(1'b1);
        for (int i = 0; i < 4; i++) begin
            d[i] = $random(seed);
            p.wcyc(1'b1, d[i]);
        end
        p.wcyc(1'b0, '0);
        rticks(3);
        chk("empty_n", 32'(empty_indicator_n), 32'h1);
        chk("ae_n", 32'(almost_empty_n), 32'h1);
        chk("af_n", 32'(almost_full_n), 32'h0);
        chk("hf_n", 32'(half_full_n), 32'h1);
        chk("full_n", 32'(full_indicator_n), 32'h1);
        chk("or_n", 32'(output_ready_n), 32'h1);
        reg_read(`DCF_ADDR_COUNT, v);
        chk("count", v, 32'h4);
        for (int i = 0; i < 2; i++) begin
            exp_q.push_back(d[i]);
            p.rcyc(1'b1);
        end
        rticks(2);
        chk("ae_n", 32'(almost_empty_n), 32'h0);
        p.wcyc(1'b0, '0);
        p.wcyc(1'b0, '0);
        chk("af_n", 32'(almost_full_n), 32'h1);
        for (int i = 2; i < 4; i++) begin
            exp_q.push_back(d[i]);
            p.rcyc(1'b1);
        end
        rticks(2);
        chk("empty_n", 32'(empty_indicator_n), 32'h0);
        // Read on empty must leave the last word standing
        exp_q.push_back(d[3]);
        p.rcyc(1'b1);

        do_reset(1'b1, 1'b1);
        reg_read(`DCF_ADDR_STATUS, v);
        chk("mode_bits", v & 32'h3, 32'h3);
        reg_write(`DCF_ADDR_EMPTY_OFS, 32'h5);
        reg_read(`DCF_ADDR_EMPTY_OFS, v);
        chk("empty_ofs", v, `DCF_OFS_SERIAL);
        reg_read(`DCF_ADDR_FULL_OFS, v);
        chk("full_ofs", v, `DCF_OFS_SERIAL);
        for (int i = 0; i < 3; i++) begin
            d[i] = $random(seed);
        end
        p.wcyc(1'b1, d[0]);
        rticks(2);
        chk("or_n", 32'(output_ready_n), 32'h1);
        rticks(1);
        chk("or_n", 32'(output_ready_n), 32'h0);
        chk("fall_word", 32'(read_data_out), 32'(d[0]));
        p.wcyc(1'b1, d[1]);
        p.wcyc(1'b1, d[2]);
        rticks(3);
        chk("ae_n", 32'(almost_empty_n), 32'h0);
        chk("ir_n", 32'(input_room_n), 32'h0);
        chk("empty_n", 32'(empty_indicator_n), 32'h1);
        chk("full_n", 32'(full_indicator_n), 32'h1);
        chk("hf_n", 32'(half_full_n), 32'h1);
        chk("af_n", 32'(almost_full_n), 32'h1);
        exp_q.push_back(d[1]);
        p.rcyc(1'b1);
        exp_q.push_back(d[2]);
        p.rcyc(1'b1);
        exp_q.push_back(d[2]);
        p.rcyc(1'b1);
        rticks(3);
        chk("or_n", 32'(output_ready_n), 32'h1);
        exp_q.push_back(d[2]);
        p.rcyc(1'b1);
        // Serial load of both offsets, empty LSB first; memory blocked
        v = $random(seed);
        sbits = {~v[16:0], v[16:0]};
        offset_load_n <= 1'b0;
        serial_en_n <= 1'b0;
        for (int i = 0; i < 34; i++) begin
            mode_select_serial_in <= sbits[i];
            p.wcyc(1'b0, '0);
        end
        offset_load_n <= 1'b1;
        serial_en_n <= 1'b1;
        reg_read(`DCF_ADDR_EMPTY_OFS, v);
        chk("serial_empty_ofs", v, 32'(sbits[16:0]));
        reg_read(`DCF_ADDR_FULL_OFS, v);
        chk("serial_full_ofs", v, 32'(sbits[33:17]));
        chk("queue_left", 32'(exp_q.size()), 32'h0);
        finish_test();
    end

endmodule : tb

// ---- src/dcf_cfg.svh ----
// Constants of the dual-clock FIFO core: bus offsets, status bit
// positions, offset presets, strap timing and depth choices.
// Assumes inclusion by bare name from the design files.
`ifndef DCF_CFG_SVH
`define DCF_CFG_SVH

`define DCF_ADDR_EMPTY_OFS 8'h00
`define DCF_ADDR_FULL_OFS 8'h04
`define DCF_ADDR_STATUS 8'h08
`define DCF_ADDR_COUNT 8'h0c

`define DCF_STS_FALL_THROUGH_MODE 0
`define DCF_STS_SERIAL 1
`define DCF_STS_OUT_VALID 2
`define DCF_STS_NOT_EMPTY 3
`define DCF_STS_ROOM 4
`define DCF_STS_AE_N 5
`define DCF_STS_AF_N 6
`define DCF_STS_HF_N 7

`define DCF_OFS_SERIAL 32'h0000_03ff
`define DCF_OFS_PARALLEL 32'h0000_007f

`define DCF_STRAP_WAIT 2'h3
`define DCF_DEPTH_SMALL 131072
`define DCF_DEPTH_LARGE 262144
`define DCF_WIDTH 18

`endif

// ---- src/dcf_fifo_core.sv ----
// Dual-clock FIFO core with status flags, oversampled on one clock.
// Assumes write and read clocks much slower than clock (>= 4x).
//
// The plain strobed port and the register addresses were decided locally.
`timescale 1ns/1ps
`include "dcf_cfg.svh"
module dcf_fifo_core #(
    parameter int DW = `DCF_WIDTH,
    parameter int DEPTH = `DCF_DEPTH_SMALL
) (
    input wire logic clock,
    input wire logic rstn,
    input wire logic wclk,
    input wire logic wen_n,
    input wire logic [DW-1:0] wdata,
    input wire logic rclk,
    input wire logic ren_n,
    input wire logic mode_select_serial_in,
    input wire logic offset_load_n,
    input wire logic serial_en_n,
    input wire logic [7:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    output logic [DW-1:0] read_data_out,
    output logic empty_indicator_n,
    output logic output_ready_n,
    output logic full_indicator_n,
    output logic input_room_n,
    output logic almost_empty_n,
    output logic almost_full_n,
    output logic half_full_n
);

    localparam int AW = $clog2(DEPTH);
    localparam int CW = AW + 2;
    localparam int PW = DW + 7;
    localparam logic [CW-1:0] DEPTH_C = CW'(DEPTH);
    localparam logic [CW-1:0] HALF_C = CW'(DEPTH / 2);
    localparam logic [AW:0] MEM_FULL = (AW + 1)'(DEPTH);

    if (!(DEPTH == `DCF_DEPTH_SMALL || DEPTH == `DCF_DEPTH_LARGE)
        || DW < 1 || DW > 32) begin : g_bad_param
        $error("dcf_fifo_core: unsupported depth or width");
    end

    typedef struct packed {
        dcf_pkg::dcf_phase_t st;
        logic [1:0] strap_cnt;
        logic fall_through_mode;
        logic ser_sel;
        logic wclk_d;
        logic rclk_d;
        logic [AW-1:0] wr_ptr;
        logic [AW-1:0] rd_ptr;
        logic [AW:0] cnt;
        logic ovalid;
        logic e_s1;
        logic e_s2;
        logic f_s1;
        logic f_s2;
        logic ae_n;
        logic af_n;
        logic hf_n;
        logic [DW-1:0] dout;
        logic [AW-1:0] eofs;
        logic [AW-1:0] fofs;
        logic [31:0] rdata;
    } dcf_state_t;

    localparam dcf_state_t RST_STATE = '{
        st: dcf_pkg::DCF_STRAP,
        f_s1: 1'b1,
        f_s2: 1'b1,
        af_n: 1'b1,
        hf_n: 1'b1,
        default: '0
    };

    dcf_state_t state_r;
    dcf_state_t state_nxt;
    logic [DW-1:0] mem [0:DEPTH-1];

    logic [PW-1:0] pin_q;
    logic sy_wclk;
    logic sy_wen_n;
    logic [DW-1:0] sy_data;
    logic sy_rclk;
    logic sy_ren_n;
    logic sy_msi;
    logic sy_ld_n;
    logic sy_sen_n;

    logic wr_rise;
    logic rd_rise;
    logic do_wr;
    logic mem_rd;
    logic pop;
    logic fill;
    logic not_empty;
    logic [CW-1:0] held;
    logic [CW-1:0] held_n;
    logic [CW-1:0] cap;

    ////////////////////////////////////////////////////////////////////////
    // Pin sampling: every pin, clocks included, through two flops

    dcf_sync2 #(.W(PW)) u_pins (
        .clock(clock),
        .rstn(rstn),
        .d({wclk, wen_n, wdata, rclk, ren_n, mode_select_serial_in,
            offset_load_n, serial_en_n}),
        .q(pin_q)
    );

    assign sy_wclk = pin_q[PW-1];
    assign sy_wen_n = pin_q[PW-2];
    assign sy_data = pin_q[PW-3:5];
    assign sy_rclk = pin_q[4];
    assign sy_ren_n = pin_q[3];
    assign sy_msi = pin_q[2];
    assign sy_ld_n = pin_q[1];
    assign sy_sen_n = pin_q[0];

    ////////////////////////////////////////////////////////////////////////
    // Register view

    function automatic logic [31:0] reg_view(
        input logic [7:0] a,
        input dcf_state_t q,
        input logic [CW-1:0] h
    );
        logic [31:0] v;
        v = 32'h0;
        case (a)
            `DCF_ADDR_EMPTY_OFS: v = 32'(q.eofs);
            `DCF_ADDR_FULL_OFS: v = 32'(q.fofs);
            `DCF_ADDR_STATUS: begin
                v[`DCF_STS_FALL_THROUGH_MODE] = q.fall_through_mode;
                v[`DCF_STS_SERIAL] = q.ser_sel;
                v[`DCF_STS_OUT_VALID] = q.ovalid;
                v[`DCF_STS_NOT_EMPTY] = q.e_s2;
                v[`DCF_STS_ROOM] = q.f_s2;
                v[`DCF_STS_AE_N] = q.ae_n;
                v[`DCF_STS_AF_N] = q.af_n;
                v[`DCF_STS_HF_N] = q.hf_n;
            end
            `DCF_ADDR_COUNT: v = 32'(h);
            default: v = 32'h0;
        endcase
        return v;
    endfunction : reg_view

    ////////////////////////////////////////////////////////////////////////
    // Next state

    always_comb begin
        state_nxt = state_r;
        held = CW'(state_r.cnt) + CW'(state_r.ovalid);
        cap = state_r.fall_through_mode ? DEPTH_C + CW'(1) : DEPTH_C;
        wr_rise = sy_wclk & ~state_r.wclk_d;
        rd_rise = sy_rclk & ~state_r.rclk_d;
        not_empty = state_r.cnt != '0;
        do_wr = 1'b0;
        mem_rd = 1'b0;
        pop = 1'b0;
        fill = 1'b0;
        held_n = held;
        state_nxt.wclk_d = sy_wclk;
        state_nxt.rclk_d = sy_rclk;
        state_nxt.rdata = reg_rd ? reg_view(reg_addr, state_r, held) : 32'h0;
        case (state_r.st)
            dcf_pkg::DCF_STRAP: begin
                // Wait for the pin pipeline to hold real strap levels
                state_nxt.strap_cnt = state_r.strap_cnt + 2'h1;
                if (state_r.strap_cnt == `DCF_STRAP_WAIT) begin
                    state_nxt.fall_through_mode = sy_msi;
                    state_nxt.ser_sel = sy_ld_n;
                    state_nxt.eofs = sy_ld_n ? AW'(`DCF_OFS_SERIAL)
                                             : AW'(`DCF_OFS_PARALLEL);
                    state_nxt.fofs = state_nxt.eofs;
                    state_nxt.st = dcf_pkg::DCF_RUN;
                end
            end
            dcf_pkg::DCF_RUN: begin
                do_wr = wr_rise & ~sy_wen_n & sy_ld_n & (held < cap)
                        & (state_r.cnt < MEM_FULL);
                if (state_r.fall_through_mode) begin
                    // read ignored with no word on outputs
                    pop = rd_rise & ~sy_ren_n & state_r.ovalid;
                    // third read edge loads first word
                    fill = rd_rise & ~state_r.ovalid & state_r.e_s2
                           & not_empty;
                    mem_rd = fill | (pop & not_empty);
                    if (mem_rd) begin
                        state_nxt.ovalid = 1'b1;
                    end else if (pop) begin
                        state_nxt.ovalid = 1'b0;
                    end
                end else begin
                    // reads only on request, never empty
                    mem_rd = rd_rise & ~sy_ren_n & state_r.e_s2 & not_empty;
                end
                if (do_wr) begin
                    state_nxt.wr_ptr = state_r.wr_ptr + AW'(1);
                end
                if (mem_rd) begin
                    state_nxt.dout = mem[state_r.rd_ptr];
                    state_nxt.rd_ptr = state_r.rd_ptr + AW'(1);
                end
                state_nxt.cnt = state_r.cnt + (AW + 1)'(do_wr)
                                - (AW + 1)'(mem_rd);
                held_n = CW'(state_nxt.cnt) + CW'(state_nxt.ovalid);
                if (rd_rise) begin
                    state_nxt.e_s1 = state_nxt.cnt != '0;
                    state_nxt.e_s2 = state_r.e_s1;
                    state_nxt.ae_n = held_n > (CW'(state_r.eofs)
                                     + CW'(state_r.fall_through_mode));
                end
                if (wr_rise) begin
                    state_nxt.f_s1 = held_n < cap;
                    state_nxt.f_s2 = state_r.f_s1;
                    state_nxt.af_n = held_n < (cap - CW'(state_r.fofs));
                end
                if (wr_rise | rd_rise) begin
                    state_nxt.hf_n = held_n < (HALF_C + CW'(1)
                                     + CW'(state_r.fall_through_mode));
                end
                if (wr_rise & ~sy_ld_n & ~sy_sen_n & sy_wen_n
                    & state_r.ser_sel) begin
                    {state_nxt.fofs, state_nxt.eofs} =
                        {sy_msi, state_r.fofs, state_r.eofs[AW-1:1]};
                end
                // parallel programming over the register port
                if (reg_wr & ~state_r.ser_sel) begin
                    if (reg_addr == `DCF_ADDR_EMPTY_OFS) begin
                        state_nxt.eofs = reg_wdata[AW-1:0];
                    end
                    if (reg_addr == `DCF_ADDR_FULL_OFS) begin
                        state_nxt.fofs = reg_wdata[AW-1:0];
                    end
                end
            end
            default: begin
                state_nxt = RST_STATE;
            end
        endcase
    end

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            state_r <= RST_STATE;
        end else begin
            state_r <= state_nxt;
        end
    end

    // Storage has no reset; contents are undefined until written
    always_ff @(posedge clock) begin
        if (do_wr) begin
            mem[state_r.wr_ptr] <= sy_data;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Outputs; the pin of the unused mode stays inactive high

    assign reg_rdata = state_r.rdata;
    assign read_data_out = state_r.dout;
    assign empty_indicator_n = state_r.fall_through_mode | state_r.e_s2;
    assign output_ready_n = ~state_r.fall_through_mode | ~state_r.ovalid;
    assign full_indicator_n = state_r.fall_through_mode | state_r.f_s2;
    assign input_room_n = ~state_r.fall_through_mode | ~state_r.f_s2;
    assign almost_empty_n = state_r.ae_n;
    assign almost_full_n = state_r.af_n;
    assign half_full_n = state_r.hf_n;

    ////////////////////////////////////////////////////////////////////////
    // Checks

    default clocking dcf_cb @(posedge clock);
    endclocking
    default disable iff (!rstn);

    AST_MODE_FIXED: assert property (
        state_r.st == dcf_pkg::DCF_RUN |=> $stable(state_r.fall_through_mode))
        else $error("mode changed after strap");

    AST_WR_COUNT: assert property (
        do_wr && !mem_rd |=> state_r.cnt == $past(state_r.cnt) + 1'b1)
        else $error("write not counted");

    AST_FULL_BLOCKS: assert property (
        !state_r.fall_through_mode && state_r.cnt == MEM_FULL |-> !do_wr)
        else $error("write taken while full");

    AST_FALL_THROUGH_MODE_CAP: assert property (
        state_r.fall_through_mode && held == DEPTH_C + CW'(1) |-> !do_wr)
        else $error("write taken at fall-through capacity");

    AST_EMPTY_IGNORE: assert property (
        state_r.cnt == '0 |-> !mem_rd ##1 (state_r.cnt == '0 || do_wr
            || $past(do_wr)))
        else $error("read taken while empty");

    AST_EF_STAGES: assert property (
        $rose(state_r.e_s2) |-> $past(state_r.e_s1) && $past(rd_rise))
        else $error("empty flag skipped a stage");

    AST_FT_FILL: assert property (
        $rose(state_r.ovalid) |-> state_r.fall_through_mode && $past(state_r.e_s2)
            && $past(rd_rise))
        else $error("fall-through word loaded early");

    AST_AE_STD: assert property (
        rd_rise && !state_r.fall_through_mode && state_r.st == dcf_pkg::DCF_RUN
            && !reg_wr && !wr_rise
        |=> state_r.ae_n == (held > CW'(state_r.eofs)))
        else $error("almost-empty threshold wrong");

    AST_HF_STD: assert property (
        (wr_rise || rd_rise) && !state_r.fall_through_mode
            && state_r.st == dcf_pkg::DCF_RUN
        |=> state_r.hf_n == (held < HALF_C + CW'(1)))
        else $error("half-full threshold wrong");

    AST_PRESET: assert property (
        state_r.st == dcf_pkg::DCF_STRAP
            && state_nxt.st == dcf_pkg::DCF_RUN && sy_ld_n
        |=> state_r.eofs == AW'(`DCF_OFS_SERIAL)
            && state_r.fofs == AW'(`DCF_OFS_SERIAL))
        else $error("serial preset wrong");

    CV_STD_WRITE: cover property (do_wr && !state_r.fall_through_mode);
    CV_FALL_THROUGH_MODE_FILL: cover property (fill);
    CV_FALL_THROUGH_MODE_POP: cover property (pop ##1 !state_r.ovalid);
    CV_SERIAL: cover property (state_r.ser_sel && wr_rise && !sy_sen_n
        && !sy_ld_n);

endmodule : dcf_fifo_core

// ---- src/dcf_pkg.sv ----
// Types shared by the dual-clock FIFO core.
// Assumes nothing of its surroundings.
package dcf_pkg;

    typedef enum logic [1:0] {
        DCF_STRAP = 2'h1,
        DCF_RUN = 2'h2
    } dcf_phase_t;

endpackage : dcf_pkg

// ---- src/dcf_sync2.sv ----
// Two-stage synchroniser for a vector of pin inputs.
// Assumes each bit is sampled independently; no bus coherence.
`timescale 1ns/1ps
module dcf_sync2 #(
    parameter int W = 1
) (
    input wire logic clock,
    input wire logic rstn,
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);

    typedef struct packed {
        logic [W-1:0] meta;
        logic [W-1:0] stable;
    } dcf_sync_t;

    dcf_sync_t sync_r;
    dcf_sync_t sync_nxt;

    if (W < 1) begin : g_bad_width
        $error("dcf_sync2: width must be at least one");
    end

    always_comb begin
        sync_nxt.meta = d;
        sync_nxt.stable = sync_r.meta;
    end

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            sync_r <= '0;
        end else begin
            sync_r <= sync_nxt;
        end
    end

    assign q = sync_r.stable;

endmodule : dcf_sync2
